// file: pkg/kli_map.svh
// Purpose: Offsets, reset values and line count of the keypad level interrupt unit
// Assumes: Special function register bus with 8-bit byte address
// Notes: Definitions only
`ifndef KLI_MAP_SVH
`define KLI_MAP_SVH

`define KLI_ADDR_POLARITY 8'h9C
`define KLI_ADDR_MASK 8'h9D
`define KLI_ADDR_FLAGS 8'h9E
`define KLI_RST_FLAGS 8'h00
`define KLI_RST_MASK 8'h00
`define KLI_RST_POLARITY 8'h00
// Pull-up idle level of the pins, so reset shows no pressed key
`define KLI_RST_PINS 8'hFF
`define KLI_LINES 8

`endif

// file: pkg/kli_pkg.sv
// Purpose: Types shared by the keypad level interrupt unit
// Assumes: Eight keypad lines
// Notes: Numbers live in kli_map.svh
package kli_pkg;
  typedef logic [7:0] kli_byte_t;
  typedef logic [7:0] kli_addr_t;
endpackage : kli_pkg

// file: verilog/kli_sync.sv
// Purpose: Two-flop synchroniser for the eight port one pins
// Assumes: Pins are asynchronous to i_clk
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
`include "kli_map.svh"
module kli_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Pins
  input wire kli_pkg::kli_byte_t i_pins,
  output kli_pkg::kli_byte_t o_pins
);
  import kli_pkg::*;

  kli_byte_t meta;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // Idle is high: a low reset value would fake a low-level match on every line
      meta <= `KLI_RST_PINS;
      o_pins <= `KLI_RST_PINS;
    end else begin
      meta <= i_pins;
      o_pins <= meta;
    end
  end
endmodule : kli_sync

// file: verilog/kli_top.sv
// Purpose: Keypad level interrupt unit on port one
// Assumes: Core register bus with one-cycle write strobe and combinational address
// Notes: Pins are synchronised; request and wake are registered
`timescale 1ns/100ps
`include "kli_map.svh"

// Functional notes
// - Eight keypad lines, each interrupting on a high or low level per line.
// - Lines are an alternate function of the port one pins.
// - Eight independent sources merge into one shared request output.
// - Global enable bit gates the combined keypad request.
// - Each line compares with its own polarity bit only.
// - A line contributes to the request only while its mask bit is set.
// - Hardware sets flag x whenever line x shows the programmed level.
// - A set flag requests only when its per-line enable bit is set.
// - Flag register resets to all zeros.
// - An enabled match wakes the core from idle and power-down.
// - One to eight lines usable; unused lines stay ordinary port pins.
// - Cleared mask leaves the pin ordinary; mask register resets to zero.
// - Polarity clear selects low, set selects high; resets to zero.
module kli_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Port one pins
  input wire kli_pkg::kli_byte_t i_port_one_pins,
  // Register bus
  input wire kli_pkg::kli_addr_t i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire kli_pkg::kli_byte_t i_wdata,
  output kli_pkg::kli_byte_t o_rdata,
  // Global enable from the second interrupt enable register
  input wire logic i_keypad_global_irq_enable,
  // Outputs
  output logic o_irq,
  output logic o_wake,
  output kli_pkg::kli_byte_t o_keypad_lines
);
  import kli_pkg::*;

  // ------------------------------------------------------------
  // Synchronised pins
  // ------------------------------------------------------------
  kli_byte_t pins_sync;
  kli_byte_t line_match_flags;
  kli_byte_t line_irq_mask;
  kli_byte_t line_polarity_select;
  kli_byte_t match;
  kli_byte_t next_flags;

  kli_sync u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pins(i_port_one_pins),
    .o_pins(pins_sync)
  );

  // XNOR: polarity 1 matches high, 0 matches low
  assign match = ~(pins_sync ^ line_polarity_select);

  function automatic logic any_request(input kli_byte_t f, input kli_byte_t m);
    any_request = |(f & m);
  endfunction : any_request

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      line_irq_mask <= `KLI_RST_MASK;
      line_polarity_select <= `KLI_RST_POLARITY;
    end else if (i_wr) begin
      if (i_addr == `KLI_ADDR_MASK) begin
        line_irq_mask <= i_wdata;
      end
      if (i_addr == `KLI_ADDR_POLARITY) begin
        line_polarity_select <= i_wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------
  // Set wins over a software clear in the same cycle, so a held key re-flags
  always_comb begin
    next_flags = line_match_flags;
    if (i_wr && i_addr == `KLI_ADDR_FLAGS) begin
      next_flags = i_wdata;
    end
    next_flags = next_flags | match;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      line_match_flags <= `KLI_RST_FLAGS;
    end else begin
      line_match_flags <= next_flags;
    end
  end

  // ------------------------------------------------------------
  // Request, wake and read-back
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
      o_wake <= 1'b0;
      o_keypad_lines <= 8'h00;
    end else begin
      o_irq <= i_keypad_global_irq_enable &
               any_request(line_match_flags, line_irq_mask);
      // Wake needs the global enable, like the request, so a disabled unit stays asleep
      o_wake <= i_keypad_global_irq_enable &
                any_request(match, line_irq_mask);
      // Masked-off lines are free for ordinary port use
      o_keypad_lines <= line_irq_mask;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        `KLI_ADDR_FLAGS: o_rdata <= line_match_flags;
        `KLI_ADDR_MASK: o_rdata <= line_irq_mask;
        `KLI_ADDR_POLARITY: o_rdata <= line_polarity_select;
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_irq_combine;
    @(posedge i_clk) disable iff (!i_reset_n)
      1'b1 |=> o_irq == ($past(i_keypad_global_irq_enable) &
                         (|($past(line_match_flags) & $past(line_irq_mask))));
  endproperty
  a_irq_combine: assert property (p_irq_combine) else $error("request mismatch");

  property p_no_global;
    @(posedge i_clk) disable iff (!i_reset_n)
      !i_keypad_global_irq_enable |=> !o_irq;
  endproperty
  a_no_global: assert property (p_no_global) else $error("request without enable");

  property p_masked_off;
    @(posedge i_clk) disable iff (!i_reset_n)
      line_irq_mask == 8'h00 |=> !o_irq && !o_wake;
  endproperty
  a_masked_off: assert property (p_masked_off) else $error("masked line requested");

  property p_flag_set;
    @(posedge i_clk) disable iff (!i_reset_n)
      1'b1 |=> (line_match_flags & $past(match)) == $past(match);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("match not flagged");

  property p_flag_sticky;
    @(posedge i_clk) disable iff (!i_reset_n)
      !(i_wr && i_addr == `KLI_ADDR_FLAGS) |=>
        (line_match_flags & $past(line_match_flags)) == $past(line_match_flags);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag self-cleared");

  property p_polarity;
    @(posedge i_clk) disable iff (!i_reset_n)
      1'b1 |=> (line_match_flags & $past(pins_sync) & $past(line_polarity_select)) ==
                 ($past(pins_sync) & $past(line_polarity_select));
  endproperty
  a_polarity: assert property (p_polarity) else $error("high level not flagged");

  property p_wake;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_keypad_global_irq_enable && |(match & line_irq_mask)) |=> o_wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on enabled match");

  property p_reclear;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_wr && i_addr == `KLI_ADDR_FLAGS && i_wdata == 8'h00) |=>
        line_match_flags == $past(match);
  endproperty
  a_reclear: assert property (p_reclear) else $error("clear during match lost");

  property p_low_level;
    @(posedge i_clk) disable iff (!i_reset_n)
      1'b1 |=> (line_match_flags & ~$past(pins_sync) & ~$past(line_polarity_select)) ==
                 (~$past(pins_sync) & ~$past(line_polarity_select));
  endproperty
  a_low_level: assert property (p_low_level) else $error("low level not flagged");

  property p_flag_write;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_wr && i_addr == `KLI_ADDR_FLAGS) |=>
        line_match_flags == ($past(i_wdata) | $past(match));
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("flag write wrong");

  property p_no_spurious;
    @(posedge i_clk) disable iff (!i_reset_n)
      !(i_wr && i_addr == `KLI_ADDR_FLAGS) |=>
        (line_match_flags & ~$past(line_match_flags) & ~$past(match)) == 8'h00;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("stray flag");

  property p_irq_unflagged;
    @(posedge i_clk) disable iff (!i_reset_n)
      (line_match_flags & line_irq_mask) == 8'h00 |=> !o_irq;
  endproperty
  a_irq_unflagged: assert property (p_irq_unflagged) else $error("stray request");

  property p_irq_any;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_keypad_global_irq_enable && |(line_match_flags & line_irq_mask)) |=> o_irq;
  endproperty
  a_irq_any: assert property (p_irq_any) else $error("enabled flag not requested");

  property p_wake_global;
    @(posedge i_clk) disable iff (!i_reset_n)
      !i_keypad_global_irq_enable |=> !o_wake;
  endproperty
  a_wake_global: assert property (p_wake_global) else $error("wake without enable");

  property p_wake_idle;
    @(posedge i_clk) disable iff (!i_reset_n)
      (match & line_irq_mask) == 8'h00 |=> !o_wake;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("stray wake");

  // ------------------------------------------------------------
  // Register and read-back checks
  // ------------------------------------------------------------
  // Reset values are checked while reset is held, so no disable here
  property p_reset_values;
    @(posedge i_clk)
      !i_reset_n |-> line_match_flags == `KLI_RST_FLAGS && line_irq_mask == `KLI_RST_MASK &&
                     line_polarity_select == `KLI_RST_POLARITY && !o_irq && !o_wake;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

  property p_mask_write;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_wr && i_addr == `KLI_ADDR_MASK) |=> line_irq_mask == $past(i_wdata);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_pol_write;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_wr && i_addr == `KLI_ADDR_POLARITY) |=> line_polarity_select == $past(i_wdata);
  endproperty
  a_pol_write: assert property (p_pol_write) else $error("polarity write lost");

  property p_cfg_hold;
    @(posedge i_clk) disable iff (!i_reset_n)
      !(i_wr && (i_addr == `KLI_ADDR_MASK || i_addr == `KLI_ADDR_POLARITY)) |=>
        $stable(line_irq_mask) && $stable(line_polarity_select);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("setting changed unwritten");

  property p_lines_copy;
    @(posedge i_clk) disable iff (!i_reset_n)
      1'b1 |=> o_keypad_lines == $past(line_irq_mask);
  endproperty
  a_lines_copy: assert property (p_lines_copy) else $error("line use wrong");

  property p_rd_flags;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_rd && i_addr == `KLI_ADDR_FLAGS) |=> o_rdata == $past(line_match_flags);
  endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("flag read wrong");

  property p_rd_mask;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_rd && i_addr == `KLI_ADDR_MASK) |=> o_rdata == $past(line_irq_mask);
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("mask read wrong");

  property p_rd_pol;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_rd && i_addr == `KLI_ADDR_POLARITY) |=> o_rdata == $past(line_polarity_select);
  endproperty
  a_rd_pol: assert property (p_rd_pol) else $error("polarity read wrong");

  property p_rd_unmapped;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_rd && i_addr != `KLI_ADDR_FLAGS && i_addr != `KLI_ADDR_MASK &&
       i_addr != `KLI_ADDR_POLARITY) |=> o_rdata == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("stray read data");

  property p_rd_hold;
    @(posedge i_clk) disable iff (!i_reset_n)
      !i_rd |=> $stable(o_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule : kli_top

// file: test/kli_keypad.sv
// Purpose: Key matrix model on the port one pins
// Assumes: A pressed key grounds its line; pull-ups hold it high
// Notes: A released line reads the pull-up level, never the last value
`timescale 1ns/100ps
module kli_keypad (
  // Keys
  input wire kli_pkg::kli_byte_t i_pressed,
  // Pins
  output kli_pkg::kli_byte_t o_pins
);
  import kli_pkg::*;
  // Any subset of the eight columns may be wired
  assign o_pins = ~i_pressed;
endmodule : kli_keypad

// file: test/testbench.sv
// Purpose: Register-level bench for the keypad level interrupt unit
// Assumes: Inputs change on the falling edge
// Notes: Waits are fixed by the pin-to-request latency
`timescale 1ns/100ps
`include "kli_map.svh"
module testbench;
  import kli_pkg::*;
  logic clk, rst_n, wr, rd, gen, irq, wake;
  kli_byte_t keys, pins, wdata, rdata, lines;
  kli_addr_t addr;
  int n_errors = 0;
  int checks = 0;
  kli_keypad u_keys (.i_pressed(keys), .o_pins(pins));
  kli_top u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_port_one_pins(pins), .i_addr(addr),
    .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
    .i_keypad_global_irq_enable(gen), .o_irq(irq), .o_wake(wake), .o_keypad_lines(lines));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input kli_addr_t a, input kli_byte_t d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input kli_addr_t a, input string nm, input kli_byte_t exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(nm, rdata, exp);
  endtask : rd_chk
  // Pin to request takes four edges; five leaves margin
  task automatic settle;
    repeat (5) @(negedge clk);
  endtask : settle
  task automatic complete_run;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    complete_run();
  end
  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    gen = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    keys = 8'h00;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(`KLI_ADDR_FLAGS, "flags", `KLI_RST_FLAGS);
    rd_chk(`KLI_ADDR_MASK, "mask", `KLI_RST_MASK);
    rd_chk(`KLI_ADDR_POLARITY, "polarity", `KLI_RST_POLARITY);
    rd_chk(8'h00, "unmapped", 8'h00);
    keys = 8'h01;
    settle();
    rd_chk(`KLI_ADDR_FLAGS, "flags", 8'h01);
    chk("irq", {7'h00, irq}, 8'h00);
    wr_reg(`KLI_ADDR_MASK, 8'h01);
    rd_chk(`KLI_ADDR_MASK, "mask", 8'h01);
    settle();
    chk("lines", lines, 8'h01);
    chk("irq", {7'h00, irq}, 8'h00);
    gen = 1'b1;
    settle();
    chk("irq", {7'h00, irq}, 8'h01);
    chk("wake", {7'h00, wake}, 8'h01);
    wr_reg(`KLI_ADDR_FLAGS, 8'h00);
    settle();
    rd_chk(`KLI_ADDR_FLAGS, "flags", 8'h01);
    keys = 8'h00;
    settle();
    rd_chk(`KLI_ADDR_FLAGS, "flags", 8'h01);
    chk("wake", {7'h00, wake}, 8'h00);
    wr_reg(`KLI_ADDR_FLAGS, 8'h00);
    settle();
    chk("irq", {7'h00, irq}, 8'h00);
    // High level on released lines: only the selected line may flag
    for (int i = 0; i < 8; i++) begin
      wr_reg(`KLI_ADDR_POLARITY, 8'h01 << i);
      wr_reg(`KLI_ADDR_MASK, 8'h01 << i);
      wr_reg(`KLI_ADDR_FLAGS, 8'h00);
      settle();
      rd_chk(`KLI_ADDR_FLAGS, "flags", 8'h01 << i);
      rd_chk(`KLI_ADDR_POLARITY, "polarity", 8'h01 << i);
      chk("irq", {7'h00, irq}, 8'h01);
    end
    // Unmapped write must leave the mask alone
    wr_reg(8'h00, 8'hFF);
    rd_chk(`KLI_ADDR_MASK, "mask", 8'h80);
    wr_reg(`KLI_ADDR_MASK, 8'h00);
    settle();
    chk("irq", {7'h00, irq}, 8'h00);
    complete_run();
  end
endmodule : testbench
